// [common/acmp_pkg.sv]
// Package: register map, field layout and types of the comparator control
// Notes on behaviour
// R1: Result bit is high when positive input exceeds negative, lagging two cycles.
// R2: Mux enable with converter off routes channel select to the negative input.
// R3: Bandgap select bit one puts the bandgap on the positive input.
// R4: Flag sets when the synchronized result shows the selected edge type.
// R5: Flag clears on vector acknowledge or a written one; zero does nothing.
// R6: Interrupt requested only while enable bit and global enable are set.
// R7: Mode codes: toggle, reserved, falling edge, rising edge.
// R8: Software disables the interrupt before changing the mode field.
// R9: Power off bit one switches the comparator off; zero restores it.
// R10: Software disables the interrupt before changing the power off bit.
// R11: Capture enable routes the result to the timer capture front end.
// R12: Buffer off bit disables the pin buffer; the pin then reads zero.
// R13: Software waits for the bandgap to settle before trusting results.
// R14: Software keeps converter power reduction at zero to use the mux.
// R15: Software also sets the timer capture interrupt enable for capture.
// R16: Converter on means the shared mux is owned by the converter.
// R17: Edges come from comparing current and previous samples each cycle.
`default_nettype none
package acmp_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_CONV_B = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_INPUT_OFF = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h3C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h40;
	// Control and status field positions
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_BANDGAP = 6;
	localparam int BIT_RESULT = 5;
	localparam int BIT_FLAG = 4;
	localparam int BIT_IRQ_EN = 3;
	localparam int BIT_CAPTURE = 2;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_MODE_LO = 0;
	// Other registers
	localparam int BIT_MUX_NEG_EN = 6;
	localparam int BIT_NEG_BUF_OFF = 1;
	localparam int BIT_POS_BUF_OFF = 0;
	localparam int BIT_EVT = 0;
	// Values after reset
	localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
	localparam logic [7:0] RST_CONV_B = 8'h00;
	localparam logic [7:0] RST_INPUT_OFF = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h01;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		MODE_TOGGLE,
		MODE_RESERVED,
		MODE_FALL,
		MODE_RISE
	} irq_mode_e;

	typedef struct packed {
		logic power_off;
		logic bandgap_pos;
		logic mux_neg;
		logic [2:0] neg_channel;
	} analog_sel_s;

	typedef struct packed {
		logic neg_off;
		logic pos_off;
	} buf_off_s;

	// Edge of the selected type between two samples
	function automatic logic edge_hit(irq_mode_e m, logic cur, logic prev);
		logic hit;
		hit = 1'b0;
		case (m)
			MODE_TOGGLE: hit = cur ^ prev;
			MODE_FALL: hit = prev & ~cur;
			MODE_RISE: hit = cur & ~prev;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction
endpackage
`default_nettype wire

// [src/acmp_sync.sv]
// Two stage level synchronizer for pin and comparator inputs
`default_nettype none
module acmp_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import acmp_pkg::*;

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// [src/analog_comparator_control.sv]
// Comparator control: APB registers, input select, edge flag, interrupt
`default_nettype none
module analog_comparator_control (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acmp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmp_raw_in,
	input wire logic pos_pin_in,
	input wire logic neg_pin_in,
	input wire logic converter_on,
	input wire logic [2:0] channel_select,
	input wire logic global_irq_enable,
	input wire logic irq_vector_ack,
	output acmp_pkg::analog_sel_s analog_sel,
	output acmp_pkg::buf_off_s buf_off,
	output logic pos_pin_read,
	output logic neg_pin_read,
	output logic capture_trigger,
	output logic compare_irq
);
	import acmp_pkg::*;

	logic [2:0] sync_q;
	logic compare_result;
	logic pos_pin_sync;
	logic neg_pin_sync;
	logic prev_result_r;
	logic comparator_power_off_r;
	logic bandgap_positive_select_r;
	logic compare_event_flag_r;
	logic compare_irq_enable_r;
	logic capture_route_enable_r;
	irq_mode_e irq_mode_r;
	logic mux_negative_select_enable_r;
	buf_off_s buf_off_nxt;
	logic [7:0] irq_mask_r;
	logic setup;
	logic access;
	logic addr_hit;
	logic wr_lane0;
	logic wr_ctrl;
	logic wr_conv_b;
	logic wr_input_off;
	logic wr_status;
	logic wr_mask;
	logic edge_evt;
	logic flag_clear;
	logic [7:0] rd_byte;
	logic [7:0] ctrl_view;

	// Comparator output and pin levels cross into the clock domain
	acmp_sync #(
		.WIDTH(3)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.async_in({cmp_raw_in, pos_pin_in, neg_pin_in}),
		.sync_out(sync_q)
	);

	assign compare_result = sync_q[2]; // [R1]
	assign pos_pin_sync = sync_q[1];
	assign neg_pin_sync = sync_q[0];

	// Bus phases and write strobes
	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr_lane0 = access & pwrite & pstrb[0];
	assign wr_ctrl = wr_lane0 & (paddr == OFS_CTRL_STATUS);
	assign wr_conv_b = wr_lane0 & (paddr == OFS_CONV_B);
	assign wr_input_off = wr_lane0 & (paddr == OFS_INPUT_OFF);
	assign wr_status = wr_lane0 & (paddr == OFS_IRQ_STATUS);
	assign wr_mask = wr_lane0 & (paddr == OFS_IRQ_MASK);

	// Address decode of the five registers
	assign addr_hit = (paddr == OFS_CTRL_STATUS) |
		(paddr == OFS_CONV_B) |
		(paddr == OFS_INPUT_OFF) |
		(paddr == OFS_IRQ_STATUS) |
		(paddr == OFS_IRQ_MASK);

	// Live view of control and status
	assign ctrl_view = {comparator_power_off_r, bandgap_positive_select_r,
		compare_result, compare_event_flag_r, compare_irq_enable_r,
		capture_route_enable_r, irq_mode_r};

	// Read multiplexer, unmapped reads return zero
	always_comb
	begin
		rd_byte = 8'h00;
		case (paddr)
			OFS_CTRL_STATUS: rd_byte = ctrl_view;
			OFS_CONV_B: rd_byte[BIT_MUX_NEG_EN] = mux_negative_select_enable_r;
			OFS_INPUT_OFF: rd_byte = {6'h00, buf_off};
			OFS_IRQ_STATUS: rd_byte[BIT_EVT] = compare_event_flag_r;
			OFS_IRQ_MASK: rd_byte = irq_mask_r;
			default: rd_byte = 8'h00;
		endcase
	end

	// No wait state: ready follows setup, drops after access
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pready <= 1'b0;
		else if (ce)
		begin
			if (setup)
				pready <= 1'b1;
			else if (access)
				pready <= 1'b0;
		end
	end

	// Read data and error captured in setup, held through access
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			if (setup)
			begin
				prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				pslverr <= ~addr_hit;
			end
			else if (access)
			begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// Control fields of the control and status register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			comparator_power_off_r <= RST_CTRL_STATUS[BIT_POWER_OFF];
			bandgap_positive_select_r <= RST_CTRL_STATUS[BIT_BANDGAP];
			compare_irq_enable_r <= RST_CTRL_STATUS[BIT_IRQ_EN];
			capture_route_enable_r <= RST_CTRL_STATUS[BIT_CAPTURE];
			irq_mode_r <= irq_mode_e'(RST_CTRL_STATUS[BIT_MODE_HI:BIT_MODE_LO]);
		end
		else if (ce && wr_ctrl)
		begin
			comparator_power_off_r <= pwdata[BIT_POWER_OFF]; // [R9]
			bandgap_positive_select_r <= pwdata[BIT_BANDGAP]; // [R3]
			compare_irq_enable_r <= pwdata[BIT_IRQ_EN]; // [R6]
			capture_route_enable_r <= pwdata[BIT_CAPTURE]; // [R11]
			irq_mode_r <= irq_mode_e'(pwdata[BIT_MODE_HI:BIT_MODE_LO]); // [R7]
		end
	end

	// Mux enable, pin buffer disables and interrupt mask
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mux_negative_select_enable_r <= RST_CONV_B[BIT_MUX_NEG_EN];
			buf_off_nxt <= buf_off_s'(RST_INPUT_OFF[1:0]);
			irq_mask_r <= RST_IRQ_MASK;
		end
		else if (ce)
		begin
			if (wr_conv_b)
				mux_negative_select_enable_r <= pwdata[BIT_MUX_NEG_EN];
			if (wr_input_off)
			begin
				buf_off_nxt.neg_off <= pwdata[BIT_NEG_BUF_OFF];
				buf_off_nxt.pos_off <= pwdata[BIT_POS_BUF_OFF];
			end
			if (wr_mask)
				irq_mask_r <= {7'h00, pwdata[BIT_EVT]};
		end
	end

	// Previous sample for edge detection
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			prev_result_r <= 1'b0;
		else if (ce)
			prev_result_r <= compare_result; // [R17]
	end

	assign edge_evt = edge_hit(irq_mode_r, compare_result,
		prev_result_r); // [R4] [R7]
	assign flag_clear = irq_vector_ack |
		(wr_ctrl & pwdata[BIT_FLAG]) |
		(wr_status & pwdata[BIT_EVT]); // [R5]

	// Sticky flag; a new edge wins over a clear
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			compare_event_flag_r <= RST_CTRL_STATUS[BIT_FLAG];
		else if (ce)
		begin
			if (edge_evt)
				compare_event_flag_r <= 1'b1; // [R4]
			else if (flag_clear)
				compare_event_flag_r <= 1'b0; // [R5]
		end
	end

	// Interrupt level gated by enable, global enable and mask
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			compare_irq <= 1'b0;
		else if (ce)
			compare_irq <= compare_event_flag_r & compare_irq_enable_r &
				global_irq_enable & irq_mask_r[BIT_EVT]; // [R6]
	end

	// Analog selects, capture route and pin reads
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			analog_sel <= '0;
			buf_off <= '0;
			capture_trigger <= 1'b0;
			pos_pin_read <= 1'b0;
			neg_pin_read <= 1'b0;
		end
		else if (ce)
		begin
			analog_sel.power_off <= comparator_power_off_r; // [R9]
			analog_sel.bandgap_pos <= bandgap_positive_select_r; // [R3]
			analog_sel.mux_neg <= mux_negative_select_enable_r &
				~converter_on; // [R2] [R16]
			if (mux_negative_select_enable_r && !converter_on)
				analog_sel.neg_channel <= channel_select; // [R2]
			buf_off <= buf_off_nxt; // [R12]
			capture_trigger <= capture_route_enable_r &
				compare_result; // [R11]
			pos_pin_read <= pos_pin_sync & ~buf_off_nxt.pos_off; // [R12]
			neg_pin_read <= neg_pin_sync & ~buf_off_nxt.neg_off; // [R12]
		end
	end

	// Result is the raw input two edges earlier
	a_result_lag: assert property ( // [R1]
		@(posedge clk) disable iff (!rst_b)
		($past(ce) && $past(ce, 2) && $past(rst_b) && $past(rst_b, 2))
		|-> compare_result == $past(cmp_raw_in, 2))
	else
		$error("result does not follow comparator by two cycles");

	// Negative input mux select
	a_neg_mux_sel: assert property ( // [R2]
		@(posedge clk) disable iff (!rst_b)
		ce |=> analog_sel.mux_neg ==
			$past(mux_negative_select_enable_r & ~converter_on))
	else
		$error("negative mux select wrong");

	// Channel tracks while mux serves the comparator
	a_neg_channel: assert property ( // [R16]
		@(posedge clk) disable iff (!rst_b)
		(ce && mux_negative_select_enable_r && !converter_on)
		|=> analog_sel.neg_channel == $past(channel_select))
	else
		$error("negative channel not taken");

	// Bandgap select reaches the analog side
	a_bandgap_sel: assert property ( // [R3]
		@(posedge clk) disable iff (!rst_b)
		(ce && wr_ctrl) ##1 ce
		|=> analog_sel.bandgap_pos == $past(pwdata[BIT_BANDGAP], 2))
	else
		$error("bandgap select not applied");

	// Selected edge sets the flag
	a_flag_on_edge: assert property ( // [R4]
		@(posedge clk) disable iff (!rst_b)
		(ce && edge_evt) |=> compare_event_flag_r)
	else
		$error("edge did not set flag");

	// Written one clears the flag without a new edge
	a_flag_w1c: assert property ( // [R5]
		@(posedge clk) disable iff (!rst_b)
		(ce && flag_clear && !edge_evt) |=> !compare_event_flag_r)
	else
		$error("flag not cleared");

	// Flag rises only on an edge
	a_flag_no_spur: assert property ( // [R5]
		@(posedge clk) disable iff (!rst_b)
		$rose(compare_event_flag_r) |-> $past(edge_evt) && $past(ce))
	else
		$error("flag set without edge");

	// Reserved mode never sets the flag
	a_reserved_quiet: assert property ( // [R7]
		@(posedge clk) disable iff (!rst_b)
		(ce && irq_mode_r == MODE_RESERVED && !compare_event_flag_r)
		|=> !compare_event_flag_r)
	else
		$error("reserved mode set flag");

	// Request needs flag, enable and global enable
	a_irq_gate: assert property ( // [R6]
		@(posedge clk) disable iff (!rst_b)
		compare_irq |-> $past(compare_irq_enable_r) &&
			$past(global_irq_enable) && $past(compare_event_flag_r))
	else
		$error("interrupt without enables");

	// Power off bit reaches the comparator
	a_power_off: assert property ( // [R9]
		@(posedge clk) disable iff (!rst_b)
		ce |=> analog_sel.power_off == $past(comparator_power_off_r))
	else
		$error("power off not applied");

	// Capture trigger stays low while the route is disabled
	a_capture_route: assert property ( // [R11]
		@(posedge clk) disable iff (!rst_b)
		(ce && !capture_route_enable_r) |=> !capture_trigger)
	else
		$error("capture driven while route disabled");

	// Disabled pin reads zero
	a_pin_read_zero: assert property ( // [R12]
		@(posedge clk) disable iff (!rst_b)
		(ce && (buf_off_nxt.pos_off || buf_off_nxt.neg_off))
		|=> !((buf_off.pos_off && pos_pin_read) ||
			(buf_off.neg_off && neg_pin_read)))
	else
		$error("disabled pin read nonzero");

	// Previous sample tracks the result
	a_prev_sample: assert property ( // [R17]
		@(posedge clk) disable iff (!rst_b)
		ce |=> prev_result_r == $past(compare_result))
	else
		$error("previous sample stale");

	// Ready one cycle after setup
	a_apb_ready: assert property (
		@(posedge clk) disable iff (!rst_b)
		(ce && setup) |=> pready)
	else
		$error("no ready after setup");
endmodule
`default_nettype wire

// [test/analog_partner.sv]
// Behavioural analog inputs, comparator and timer capture counter
`default_nettype none
module analog_partner
	import acmp_pkg::*;
#(
	parameter logic [15:0] BANDGAP_MV = 16'd1100
) (
	input wire logic clk,
	input wire acmp_pkg::analog_sel_s analog_sel,
	input wire logic capture_trigger,
	input wire logic [15:0] pos_mv,
	input wire logic [15:0] neg_mv,
	output logic cmp_raw_in,
	output logic pos_pin_in,
	output logic neg_pin_in,
	output logic [7:0] captures
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] pos_v;
	logic [15:0] neg_v;
	logic trig_q;
	// Channel k of the shared mux sits at 256k millivolts
	always_comb
	begin
		pos_v = analog_sel.bandgap_pos ? BANDGAP_MV : pos_mv;
		neg_v = analog_sel.mux_neg ?
			{5'h00, analog_sel.neg_channel, 8'h00} : neg_mv;
		cmp_raw_in = !analog_sel.power_off && (pos_v > neg_v);
		pos_pin_in = pos_mv > 16'd1000;
		neg_pin_in = neg_mv > 16'd1000;
	end
	// Counts rising edges reaching the capture front end
	// Timer capture interrupt enable taken as set on this side
	always @(posedge clk)
	begin
		trig_q <= capture_trigger;
		if (capture_trigger && !trig_q)
			captures <= captures + 8'h01;
	end
	initial captures = 8'h00;
	initial trig_q = 1'b0;
endmodule
`default_nettype wire

// [test/test_analog_comparator_control.sv]
// Self-checking bench for the comparator control block
`default_nettype none
module test_analog_comparator_control;
	import acmp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cmp_raw_in;
	logic pos_pin_in;
	logic neg_pin_in;
	logic converter_on = 1'b0;
	logic [2:0] channel_select = 3'h0;
	logic global_irq_enable = 1'b0;
	logic irq_vector_ack = 1'b0;
	analog_sel_s analog_sel;
	buf_off_s buf_off;
	logic pos_pin_read;
	logic neg_pin_read;
	logic capture_trigger;
	logic compare_irq;
	logic [15:0] pos_mv = 16'd0;
	logic [15:0] neg_mv = 16'd500;
	logic [7:0] captures;
	logic [31:0] rdat;
	logic rerr;
	logic [7:0] n0;
	int miscompares = 0;
	int cmp_count = 0;
	// Clock of 50 ns period
	initial
	begin
		forever #25 clk = ~clk;
	end
	analog_comparator_control analog_comparator_control_inst (.clk(clk),
		.rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_raw_in(cmp_raw_in), .pos_pin_in(pos_pin_in),
		.neg_pin_in(neg_pin_in), .converter_on(converter_on),
		.channel_select(channel_select),
		.global_irq_enable(global_irq_enable),
		.irq_vector_ack(irq_vector_ack), .analog_sel(analog_sel),
		.buf_off(buf_off), .pos_pin_read(pos_pin_read),
		.neg_pin_read(neg_pin_read), .capture_trigger(capture_trigger),
		.compare_irq(compare_irq));
	analog_partner analog_partner_inst (.clk(clk), .analog_sel(analog_sel),
		.capture_trigger(capture_trigger), .pos_mv(pos_mv), .neg_mv(neg_mv),
		.cmp_raw_in(cmp_raw_in), .pos_pin_in(pos_pin_in),
		.neg_pin_in(neg_pin_in), .captures(captures));
	// Verdict and end of run
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; answer taken while pready stands
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Request held until pready is seen at a rising edge
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready wait", 1, n);
	endtask
	task automatic settle();
		repeat (6) @(negedge clk);
	endtask
	task automatic set_pos(input logic [15:0] v);
		@(posedge clk);
		pos_mv <= v;
		settle();
	endtask
	task automatic t_reset();
		apb(1'b0, 8'h30, 0);
		chk("ctrl reset", 32'h0000_0000, rdat);
		chk("ctrl err", 0, {31'h0, rerr});
		apb(1'b0, 8'h40, 0);
		chk("mask reset", 32'h0000_0001, rdat);
		pstrb <= 4'h0;
		apb(1'b1, 8'h40, 0);
		pstrb <= 4'hF;
		apb(1'b0, 8'h40, 0);
		chk("mask strobe off", 32'h0000_0001, rdat);
		apb(1'b0, 8'h38, 0);
		chk("disable reset", 32'h0000_0000, rdat);
		apb(1'b1, 8'h44, 32'hFFFF_FFFF);
		chk("unmapped err", 1, {31'h0, rerr});
	endtask
	task automatic t_select();
		apb(1'b1, 8'h30, 32'h0000_0040);
		settle();
		chk("bandgap sel", 1, {31'h0, analog_sel.bandgap_pos});
		apb(1'b0, 8'h30, 0);
		chk("result bandgap", 1, {31'h0, rdat[5]});
		@(posedge clk);
		channel_select <= 3'h5;
		apb(1'b1, 8'h34, 32'h0000_0040);
		apb(1'b0, 8'h34, 0);
		chk("conv b", 32'h0000_0040, rdat);
		settle();
		chk("mux neg", 1, {31'h0, analog_sel.mux_neg});
		chk("channel", 5, {29'h0, analog_sel.neg_channel});
		apb(1'b0, 8'h30, 0);
		chk("result channel", 0, {31'h0, rdat[5]});
		@(posedge clk);
		converter_on <= 1'b1;
		settle();
		chk("mux busy", 0, {31'h0, analog_sel.mux_neg});
		apb(1'b1, 8'h34, 0);
		apb(1'b1, 8'h30, 0);
		@(posedge clk);
		converter_on <= 1'b0;
	endtask
	task automatic t_pins();
		@(posedge clk);
		neg_mv <= 16'd1500;
		set_pos(16'd2000);
		chk("pos pin", 1, {31'h0, pos_pin_read});
		chk("neg pin", 1, {31'h0, neg_pin_read});
		apb(1'b1, 8'h38, 32'h0000_0001);
		settle();
		chk("pos pin off", 0, {31'h0, pos_pin_read});
		chk("pos buf off", 1, {31'h0, buf_off.pos_off});
		apb(1'b1, 8'h38, 32'h0000_0002);
		settle();
		chk("neg pin off", 0, {31'h0, neg_pin_read});
		chk("neg buf off", 1, {31'h0, buf_off.neg_off});
		chk("pos pin back", 1, {31'h0, pos_pin_read});
		apb(1'b1, 8'h38, 0);
		@(posedge clk);
		neg_mv <= 16'd500;
		set_pos(16'd0);
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, 8'h30, 32'h10 | m);
			set_pos(16'd2000);
			apb(1'b0, 8'h30, 0);
			chk("rise flag", {31'h0, m == 0 || m == 3}, {31'h0, rdat[4]});
			apb(1'b1, 8'h30, 32'h10 | m);
			set_pos(16'd0);
			apb(1'b0, 8'h30, 0);
			chk("fall flag", {31'h0, m == 0 || m == 2}, {31'h0, rdat[4]});
		end
	endtask
	task automatic t_irq();
		@(posedge clk);
		global_irq_enable <= 1'b1;
		apb(1'b1, 8'h30, 32'h0000_001B);
		set_pos(16'd2000);
		chk("irq on", 1, {31'h0, compare_irq});
		@(posedge clk);
		global_irq_enable <= 1'b0;
		settle();
		chk("irq global off", 0, {31'h0, compare_irq});
		@(posedge clk);
		global_irq_enable <= 1'b1;
		apb(1'b1, 8'h40, 0);
		settle();
		chk("irq masked", 0, {31'h0, compare_irq});
		apb(1'b1, 8'h40, 32'h0000_0001);
		apb(1'b1, 8'h30, 32'h0000_000B);
		apb(1'b0, 8'h30, 0);
		chk("zero write keeps", 1, {31'h0, rdat[4]});
		@(posedge clk);
		irq_vector_ack <= 1'b1;
		@(posedge clk);
		irq_vector_ack <= 1'b0;
		apb(1'b0, 8'h30, 0);
		chk("ack clears", 0, {31'h0, rdat[4]});
		apb(1'b1, 8'h30, 32'h0000_0003);
		set_pos(16'd0);
		set_pos(16'd2000);
		chk("irq enable off", 0, {31'h0, compare_irq});
		apb(1'b0, 8'h3C, 0);
		chk("status set", 1, rdat);
		apb(1'b1, 8'h3C, 32'h0000_0001);
		apb(1'b0, 8'h3C, 0);
		chk("status w1c", 0, rdat);
		set_pos(16'd0);
	endtask
	task automatic t_capture();
		apb(1'b1, 8'h30, 32'h0000_0004);
		n0 = captures;
		set_pos(16'd2000);
		chk("capture on", 1, {31'h0, capture_trigger});
		chk("capture count", {24'h0, n0 + 8'h01}, {24'h0, captures});
		set_pos(16'd0);
		apb(1'b1, 8'h30, 0);
		set_pos(16'd2000);
		chk("capture off", 0, {31'h0, capture_trigger});
		set_pos(16'd0);
		apb(1'b1, 8'h30, 32'h0000_0080);
		settle();
		chk("power off", 1, {31'h0, analog_sel.power_off});
		apb(1'b1, 8'h30, 0);
		settle();
		chk("power on", 0, {31'h0, analog_sel.power_off});
		// Clock enable low freezes the pin path
		@(posedge clk);
		ce <= 1'b0;
		pos_mv <= 16'd2000;
		settle();
		chk("ce freeze", 0, {31'h0, pos_pin_read});
		@(posedge clk);
		ce <= 1'b1;
		settle();
		chk("ce resume", 1, {31'h0, pos_pin_read});
	endtask
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_select();
		t_pins();
		t_modes();
		t_irq();
		t_capture();
		conclude();
	end
	// Watchdog against a hung handshake
	initial
	begin
		#1000000;
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
